// [common/ldl_pkg.sv]
// Package with the register map, field positions and reset values of the control register group.
package ldl_pkg;

  // Bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register byte offsets on the register port.
  localparam logic [7:0] ADDR_SHORT_TH   = 8'h5B;
  localparam logic [7:0] ADDR_CLEAR      = 8'h60;
  localparam logic [7:0] ADDR_LOCK       = 8'h61;
  localparam logic [7:0] ADDR_EEADC      = 8'h62;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h68;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h69;

  // Clear-control field positions.
  localparam int CLR_FORCE_FS_BIT  = 5;
  localparam int CLR_RESTORE_BIT   = 4;
  localparam int CLR_FORCE_ERR_BIT = 3;
  localparam int CLR_EXIT_FS_BIT   = 2;
  localparam int CLEAR_FAULT_FLAGS_BIT     = 1;
  localparam int CLEAR_POWERUP_FLAG_BIT       = 0;
  localparam int CLR_CMD_W         = 6;

  // Write-protect field positions.
  localparam int LOCK_CLEAR_BIT   = 3;
  localparam int LOCK_CONFIG_BIT  = 2;
  localparam int LOCK_CURRENT_BIT = 1;
  localparam int LOCK_DUTY_BIT    = 0;
  localparam int LOCK_W           = 4;

  // EEPROM and ADC control field positions.
  localparam int EEADC_STAY_BIT     = 7;
  localparam int EEADC_READBACK_BIT = 6;
  localparam int ADC_CH_W           = 5;

  // Positions in the internal command pulse vector.
  localparam int CMD_READBACK_BIT = 6;
  localparam int CMD_ADC_BIT      = 7;
  localparam int CMD_W            = 8;

  // Interrupt event positions.
  localparam int IRQ_EV_REFUSED = 0;
  localparam int IRQ_EV_ADC     = 1;
  localparam int IRQ_EV_FS      = 2;
  localparam int IRQ_EV_EEPROM  = 3;
  localparam int IRQ_W          = 4;

  // Values after reset.
  localparam logic [LOCK_W-1:0]   LOCK_RESET     = 4'hF;
  localparam logic [ADC_CH_W-1:0] ADC_CH_RESET   = 5'h00;
  localparam logic [7:0]          SHORT_TH_RESET = 8'h00;
  localparam logic [IRQ_W-1:0]    IRQ_MASK_RESET = 4'h0;

  // Threshold loader states.
  typedef enum logic [1:0] {
    LDL_ST_LOAD = 2'b01,
    LDL_ST_RUN  = 2'b10
  } ldl_state_e;

endpackage

// [rtl/ldl_cmd_pulse.sv]
// Registered one-cycle command pulses for the self-clearing control bits.
`timescale 1ns/1ps
`default_nettype none
module ldl_cmd_pulse #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] fire_i,
  output logic      [W-1:0] pulse_o
);

  logic [W-1:0] pulse;
  logic [W-1:0] next_pulse;

  // A command lives for exactly one enabled cycle; while the clock enable is low it is frozen.
  always_comb begin
    next_pulse = pulse;
    if (ce_i) begin
      next_pulse = fire_i;
    end
  end

  // Registers only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse <= '0;
    end else begin
      pulse <= next_pulse;
    end
  end

  assign pulse_o = pulse;

endmodule
`default_nettype wire

// [rtl/ldl_ctrl_regs.sv]
// Control, command and write-protect register group of the LED driver.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ldl_ctrl_regs
  import ldl_pkg::*;
(
  input  wire logic                         CLK_I,
  input  wire logic                         RST_B_I,
  input  wire logic                         CE_I,
  input  wire logic [ldl_pkg::ADDR_W-1:0]   ADDR_I,
  input  wire logic [ldl_pkg::DATA_W-1:0]   WDATA_I,
  input  wire logic                         WR_I,
  input  wire logic                         RD_I,
  output logic      [ldl_pkg::DATA_W-1:0]   RDATA_O,
  input  wire logic [7:0]                   STORED_THRESH_I,
  input  wire logic                         FAULT_I,
  output logic      [7:0]                   ADC_SHORT_TH_O,
  output logic                              FORCE_FS_O,
  output logic                              RESTORE_DEFAULTS_O,
  output logic                              FORCE_ERR_O,
  output logic                              EXIT_FS_O,
  output logic                              CLEAR_FAULTS_O,
  output logic                              CLEAR_POR_O,
  output logic                              ERR_O,
  output logic                              ERR_OE_O,
  output logic                              CLEAR_REG_LOCKED_O,
  output logic                              CONFIG_LOCKED_O,
  output logic                              CURRENT_LOCKED_O,
  output logic                              DUTY_LOCKED_O,
  output logic                              STAY_EEPROM_O,
  output logic                              EEPROM_OVERWRITE_O,
  output logic      [ldl_pkg::ADC_CH_W-1:0] ADC_CH_O,
  output logic                              ADC_START_O,
  output logic                              IRQ_O
);

  import ldl_pkg::*;

  // Tells whether an address falls in the group guarded by the configuration lock.
  function automatic logic is_config_addr(input logic [ADDR_W-1:0] a);
    is_config_addr = (a == ADDR_SHORT_TH) || (a == ADDR_EEADC);
  endfunction

  // Tells whether a write to this address is blocked by the current lock setting.
  function automatic logic write_blocked(input logic [ADDR_W-1:0] a,
                                         input logic [LOCK_W-1:0] lk);
    write_blocked = ((a == ADDR_CLEAR) && lk[LOCK_CLEAR_BIT]) ||
                    (is_config_addr(a) && lk[LOCK_CONFIG_BIT]);
  endfunction

  // Stored state.
  logic [7:0]          short_th;
  logic [LOCK_W-1:0]   lock;
  logic                stay_eeprom;
  logic [ADC_CH_W-1:0] adc_ch;
  logic [IRQ_W-1:0]    irq_mask;
  logic                err_forced;
  logic                err_drive;
  logic [DATA_W-1:0]   rdata;
  ldl_state_e          state;

  // Next values.
  logic [7:0]          next_short_th;
  logic [LOCK_W-1:0]   next_lock;
  logic                next_stay_eeprom;
  logic [ADC_CH_W-1:0] next_adc_ch;
  logic [IRQ_W-1:0]    next_irq_mask;
  logic                next_err_forced;
  logic                next_err_drive;
  logic [DATA_W-1:0]   next_rdata;
  ldl_state_e          next_state;

  // Decoded write strobes and command vector.
  logic              wr_ok;
  logic              wr_refused;
  logic [CMD_W-1:0]  cmd_fire;
  logic [CMD_W-1:0]  cmd_pulse;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [IRQ_W-1:0]  irq_status;
  logic              restore;
  logic              readback;
  logic              wr_th;
  logic              wr_clear;
  logic              wr_eeadc;
  logic              wr_lock;
  logic              wr_status;
  logic              wr_mask;

  // Write qualification: a locked target swallows the write and raises an event.
  always_comb begin
    wr_ok      = WR_I && !write_blocked(ADDR_I, lock);
    wr_refused = WR_I && write_blocked(ADDR_I, lock);
  end

  // Per-register write strobes; the lock check is folded in where a lock applies.
  always_comb begin
    wr_th     = wr_ok && (ADDR_I == ADDR_SHORT_TH);
    wr_clear  = wr_ok && (ADDR_I == ADDR_CLEAR);
    wr_eeadc  = wr_ok && (ADDR_I == ADDR_EEADC);
    wr_lock   = WR_I && (ADDR_I == ADDR_LOCK);
    wr_status = WR_I && (ADDR_I == ADDR_IRQ_STATUS);
    wr_mask   = WR_I && (ADDR_I == ADDR_IRQ_MASK);
  end

  // Command bits never get stored; a one written becomes a single pulse instead.
  // Several ones in one write fire together; ordering their effects is left to the engines.
  always_comb begin
    cmd_fire = '0;
    if (wr_clear) begin
      cmd_fire[CLR_CMD_W-1:0] = WDATA_I[CLR_CMD_W-1:0];
    end
    if (wr_eeadc) begin
      cmd_fire[CMD_READBACK_BIT] = WDATA_I[EEADC_READBACK_BIT];
      cmd_fire[CMD_ADC_BIT]      = 1'b1;
    end
  end

  // The pulse generator delays every command by one cycle so that the outputs are registered.
  ldl_cmd_pulse #(
    .W (CMD_W)
  ) u_cmd (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .ce_i    (CE_I),
    .fire_i  (cmd_fire),
    .pulse_o (cmd_pulse)
  );

  assign restore  = cmd_pulse[CLR_RESTORE_BIT];
  assign readback = cmd_pulse[CMD_READBACK_BIT];

  // Loader: the threshold cannot come from a port under asynchronous reset, so it is
  // fetched from the stored copy in the first enabled cycle after release.
  // A host write to the threshold in a load cycle is lost, so software waits one
  // cycle after reset, a restore or a readback before writing it.
  always_comb begin
    next_state = state;
    if (CE_I) begin
      unique case (state)
        LDL_ST_LOAD: begin
          next_state = LDL_ST_RUN;
        end
        LDL_ST_RUN: begin
          if (restore || readback) begin
            next_state = LDL_ST_LOAD;
          end
        end
      endcase
    end
  end

  // Threshold register; the loader wins over a host write landing in the same cycle.
  always_comb begin
    next_short_th = short_th;
    if (CE_I) begin
      if (state == LDL_ST_LOAD) begin
        next_short_th = STORED_THRESH_I;
      end else if (wr_th) begin
        next_short_th = WDATA_I;
      end
    end
  end

  // Lock register: always writable itself, otherwise it could never be opened again.
  // A restore re-arms every protection, so software has to unlock again afterwards.
  always_comb begin
    next_lock = lock;
    if (CE_I) begin
      if (restore) begin
        next_lock = LOCK_RESET;
      end else if (wr_lock) begin
        next_lock = WDATA_I[LOCK_W-1:0];
      end
    end
  end

  // EEPROM mode level and ADC channel; the readback bit itself is not stored.
  // Any accepted write starts a conversion, even when the channel is unchanged.
  always_comb begin
    next_stay_eeprom = stay_eeprom;
    next_adc_ch      = adc_ch;
    if (CE_I) begin
      if (restore) begin
        next_stay_eeprom = 1'b0;
        next_adc_ch      = ADC_CH_RESET;
      end else if (wr_eeadc) begin
        next_stay_eeprom = WDATA_I[EEADC_STAY_BIT];
        next_adc_ch      = WDATA_I[ADC_CH_W-1:0];
      end
    end
  end

  // Interrupt mask; it sits outside the protected groups and survives a restore.
  always_comb begin
    next_irq_mask = irq_mask;
    if (CE_I && wr_mask) begin
      next_irq_mask = WDATA_I[IRQ_W-1:0];
    end
  end

  // Forced error: held once requested, dropped by a fault clear or a restore, since a
  // one-cycle low on the pin would be too short for any external observer.
  // The fault input shares the pin, so the pin is pulled low while either one holds.
  always_comb begin
    next_err_forced = err_forced;
    next_err_drive  = err_drive;
    if (CE_I) begin
      if (cmd_pulse[CLR_FORCE_ERR_BIT]) begin
        next_err_forced = 1'b1;
      end else if (cmd_pulse[CLEAR_FAULT_FLAGS_BIT] || restore) begin
        next_err_forced = 1'b0;
      end
      next_err_drive = next_err_forced || FAULT_I;
    end
  end

  // Interrupt events and write-one-to-clear of the status bits.
  // A refused write raises an event so that software learns a lock was still set.
  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_EV_REFUSED] = wr_refused;
    irq_set[IRQ_EV_ADC]     = cmd_pulse[CMD_ADC_BIT];
    irq_set[IRQ_EV_FS]      = cmd_pulse[CLR_FORCE_FS_BIT];
    irq_set[IRQ_EV_EEPROM]  = readback;
    irq_clr                 = '0;
    if (wr_status) begin
      irq_clr = WDATA_I[IRQ_W-1:0];
    end
  end

  ldl_irq_sticky #(
    .W (IRQ_W)
  ) u_irq (
    .clk_i    (CLK_I),
    .rst_b_i  (RST_B_I),
    .ce_i     (CE_I),
    .set_i    (irq_set),
    .clr_i    (irq_clr),
    .mask_i   (irq_mask),
    .status_o (irq_status),
    .irq_o    (IRQ_O)
  );

  // Read data stand for one enabled cycle after the strobe and are zero in other enabled cycles; they hold while the clock enable is low.
  // Reads have no side effect, so polling the status register cannot lose an event.
  always_comb begin
    next_rdata = rdata;
    if (CE_I) begin
      next_rdata = '0;
      if (RD_I) begin
        unique case (ADDR_I)
          ADDR_SHORT_TH: begin
            next_rdata = short_th;
          end
          ADDR_CLEAR: begin
            next_rdata = '0;
          end
          ADDR_LOCK: begin
            next_rdata = {4'h0, lock};
          end
          ADDR_EEADC: begin
            next_rdata = {stay_eeprom, 2'b00, adc_ch};
          end
          ADDR_IRQ_STATUS: begin
            next_rdata = {4'h0, irq_status};
          end
          ADDR_IRQ_MASK: begin
            next_rdata = {4'h0, irq_mask};
          end
          default: begin
            next_rdata = '0;
          end
        endcase
      end
    end
  end

  // Registers only.
  // The threshold holds zero only until the loader's first enabled cycle.
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state       <= LDL_ST_LOAD;
      short_th    <= SHORT_TH_RESET;
      lock        <= LOCK_RESET;
      stay_eeprom <= 1'b0;
      adc_ch      <= ADC_CH_RESET;
      irq_mask    <= IRQ_MASK_RESET;
      err_forced  <= 1'b0;
      err_drive   <= 1'b0;
      rdata       <= '0;
    end else begin
      state       <= next_state;
      short_th    <= next_short_th;
      lock        <= next_lock;
      stay_eeprom <= next_stay_eeprom;
      adc_ch      <= next_adc_ch;
      irq_mask    <= next_irq_mask;
      err_forced  <= next_err_forced;
      err_drive   <= next_err_drive;
      rdata       <= next_rdata;
    end
  end

  // Outputs.
  // The lock levels are exported because the current and duty registers live outside
  // this group and must apply the protection themselves.
  assign RDATA_O            = rdata;
  assign ADC_SHORT_TH_O     = short_th;
  assign FORCE_FS_O         = cmd_pulse[CLR_FORCE_FS_BIT];
  assign RESTORE_DEFAULTS_O = restore;
  assign FORCE_ERR_O        = cmd_pulse[CLR_FORCE_ERR_BIT];
  assign EXIT_FS_O          = cmd_pulse[CLR_EXIT_FS_BIT];
  assign CLEAR_FAULTS_O     = cmd_pulse[CLEAR_FAULT_FLAGS_BIT];
  assign CLEAR_POR_O        = cmd_pulse[CLEAR_POWERUP_FLAG_BIT];
  assign ERR_O              = 1'b0; // Open drain: only ever pulls low.
  assign ERR_OE_O           = err_drive;
  assign CLEAR_REG_LOCKED_O = lock[LOCK_CLEAR_BIT];
  assign CONFIG_LOCKED_O    = lock[LOCK_CONFIG_BIT];
  assign CURRENT_LOCKED_O   = lock[LOCK_CURRENT_BIT];
  assign DUTY_LOCKED_O      = lock[LOCK_DUTY_BIT];
  assign STAY_EEPROM_O      = stay_eeprom;
  assign EEPROM_OVERWRITE_O = readback;
  assign ADC_CH_O           = adc_ch;
  assign ADC_START_O        = cmd_pulse[CMD_ADC_BIT];

endmodule
`default_nettype wire

// [rtl/ldl_irq_sticky.sv]
// Sticky interrupt status bits with write-one-to-clear and a masked level output.
`timescale 1ns/1ps
`default_nettype none
module ldl_irq_sticky #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  input  wire logic [W-1:0] mask_i,
  output logic      [W-1:0] status_o,
  output logic              irq_o
);

  logic [W-1:0] status;
  logic [W-1:0] next_status;

  // Per bit, a new event beats a clear in the same cycle so that no event is lost.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        next_status[g] = status[g];
        if (ce_i) begin
          next_status[g] = set_i[g] | (status[g] & ~clr_i[g]);
        end
      end
    end
  endgenerate

  // Registers only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign status_o = status;
  assign irq_o    = |(status & mask_i); // Mask bit set lets the event through.

endmodule
`default_nettype wire

// [tb/ldl_ctrl_regs_asserts.sv]
// Concurrent checks on the ports of the control register group.
`timescale 1ns/1ps
`default_nettype none
module ldl_ctrl_asserts
  import ldl_pkg::*;
(
  input wire logic                         CLK_I,
  input wire logic                         RST_B_I,
  input wire logic                         CE_I,
  input wire logic [ldl_pkg::ADDR_W-1:0]   ADDR_I,
  input wire logic [ldl_pkg::DATA_W-1:0]   WDATA_I,
  input wire logic                         WR_I,
  input wire logic                         RD_I,
  input wire logic [ldl_pkg::DATA_W-1:0]   RDATA_O,
  input wire logic [7:0]                   ADC_SHORT_TH_O,
  input wire logic                         FORCE_FS_O,
  input wire logic                         RESTORE_DEFAULTS_O,
  input wire logic                         FORCE_ERR_O,
  input wire logic                         EXIT_FS_O,
  input wire logic                         CLEAR_FAULTS_O,
  input wire logic                         CLEAR_POR_O,
  input wire logic                         ERR_O,
  input wire logic                         ERR_OE_O,
  input wire logic                         CLEAR_REG_LOCKED_O,
  input wire logic                         CONFIG_LOCKED_O,
  input wire logic                         CURRENT_LOCKED_O,
  input wire logic                         DUTY_LOCKED_O,
  input wire logic                         STAY_EEPROM_O,
  input wire logic                         EEPROM_OVERWRITE_O,
  input wire logic [ldl_pkg::ADC_CH_W-1:0] ADC_CH_O,
  input wire logic                         ADC_START_O,
  input wire logic                         IRQ_O
);
  // Bus writes per register, before the lock check; the clock enable gates every transfer.
  wire       wr_clr = CE_I && WR_I && (ADDR_I == ADDR_CLEAR);
  wire       wr_ee  = CE_I && WR_I && (ADDR_I == ADDR_EEADC);
  wire       wr_th  = CE_I && WR_I && (ADDR_I == ADDR_SHORT_TH);
  wire       go_clr = wr_clr && !CLEAR_REG_LOCKED_O;
  wire [3:0] lks    = {CLEAR_REG_LOCKED_O, CONFIG_LOCKED_O, CURRENT_LOCKED_O, DUTY_LOCKED_O};
  wire [5:0] pulses = {FORCE_FS_O, RESTORE_DEFAULTS_O, FORCE_ERR_O, EXIT_FS_O,
                       CLEAR_FAULTS_O, CLEAR_POR_O};

  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_force_fs: assert property (go_clr && WDATA_I[5] |=> FORCE_FS_O)
    else $error("force fail-safe pulse missing");
  a_restore_all: assert property (go_clr && WDATA_I[4] |=> RESTORE_DEFAULTS_O ##1 (lks == 4'hF))
    else $error("restore pulse or lock defaults missing");
  a_err_drive: assert property (go_clr && WDATA_I[3] |=> FORCE_ERR_O ##1 (ERR_OE_O && !ERR_O))
    else $error("error pin not pulled low");
  a_exit_fs: assert property (go_clr && WDATA_I[2] |=> EXIT_FS_O)
    else $error("exit fail-safe pulse missing");
  a_fault_clear: assert property (go_clr && WDATA_I[1] |=> CLEAR_FAULTS_O)
    else $error("clear faults pulse missing");
  a_por_clear: assert property (go_clr && WDATA_I[0] |=> CLEAR_POR_O)
    else $error("clear power-up pulse missing");
  a_clear_locked: assert property (wr_clr && CLEAR_REG_LOCKED_O |=> (pulses == 6'h00))
    else $error("locked clear write took effect");
  a_cfg_locked: assert property ((wr_ee || wr_th) && CONFIG_LOCKED_O
                                 |=> !ADC_START_O && $stable(ADC_CH_O))
    else $error("locked config write took effect");
  a_lock_write: assert property (CE_I && WR_I && (ADDR_I == ADDR_LOCK)
                                 |=> (lks == $past(WDATA_I[3:0])))
    else $error("lock bits not written");
  a_lock_read: assert property (CE_I && RD_I && (ADDR_I == ADDR_LOCK)
                                |=> (RDATA_O == {4'h0, lks}))
    else $error("lock read value wrong");
  a_stay_level: assert property (wr_ee && !CONFIG_LOCKED_O
                                 |=> (STAY_EEPROM_O == $past(WDATA_I[7])))
    else $error("stay level wrong");
  a_readback_go: assert property (wr_ee && WDATA_I[6] && !CONFIG_LOCKED_O |=> EEPROM_OVERWRITE_O)
    else $error("overwrite pulse missing");
  a_adc_start: assert property (wr_ee && !CONFIG_LOCKED_O
                                |=> ADC_START_O && (ADC_CH_O == $past(WDATA_I[4:0])))
    else $error("conversion start or channel wrong");
  a_clear_reads0: assert property (CE_I && RD_I && (ADDR_I == ADDR_CLEAR) |=> (RDATA_O == 8'h00))
    else $error("clear register read not zero");
  a_thresh_write: assert property (wr_th && !CONFIG_LOCKED_O
                                   |=> (ADC_SHORT_TH_O == $past(WDATA_I)))
    else $error("threshold not written");

  // Main scenarios seen at least once.
  c_force_fs: cover property (go_clr ##1 FORCE_FS_O);
  c_adc_start: cover property (ADC_START_O);
  c_irq: cover property (IRQ_O);
endmodule
`default_nettype wire

// [tb/ldl_ctrl_regs_bench.sv]
// Self-checking bench for the control register group.
`timescale 1ns/1ps
`default_nettype none
bind ldl_ctrl_regs ldl_ctrl_asserts u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ADC_SHORT_TH_O(ADC_SHORT_TH_O),
  .FORCE_FS_O(FORCE_FS_O), .RESTORE_DEFAULTS_O(RESTORE_DEFAULTS_O), .FORCE_ERR_O(FORCE_ERR_O),
  .EXIT_FS_O(EXIT_FS_O), .CLEAR_FAULTS_O(CLEAR_FAULTS_O), .CLEAR_POR_O(CLEAR_POR_O),
  .ERR_O(ERR_O), .ERR_OE_O(ERR_OE_O), .CLEAR_REG_LOCKED_O(CLEAR_REG_LOCKED_O),
  .CONFIG_LOCKED_O(CONFIG_LOCKED_O), .CURRENT_LOCKED_O(CURRENT_LOCKED_O),
  .DUTY_LOCKED_O(DUTY_LOCKED_O), .STAY_EEPROM_O(STAY_EEPROM_O),
  .EEPROM_OVERWRITE_O(EEPROM_OVERWRITE_O), .ADC_CH_O(ADC_CH_O), .ADC_START_O(ADC_START_O),
  .IRQ_O(IRQ_O)
);
module ldl_ctrl_regs_bench;
  import ldl_pkg::*;
  logic       clk, rst_b, ce, wr_s, rd_s, fault;
  logic [7:0] addr, wdata, stored, rdata, th;
  logic [4:0] ch;
  logic       fs, rdef, ferr, xfs, cflt, cpor, err, err_oe, lk3, lk2, lk1, lk0;
  logic       stay, eeov, adc_go, irq;
  int         n_fail, num_checks, cyc;
  wire  [5:0] pulses = {fs, rdef, ferr, xfs, cflt, cpor};
  wire  [3:0] lks    = {lk3, lk2, lk1, lk0};

  ldl_ctrl_regs u_dut (
    .CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .STORED_THRESH_I(stored), .FAULT_I(fault),
    .ADC_SHORT_TH_O(th), .FORCE_FS_O(fs), .RESTORE_DEFAULTS_O(rdef), .FORCE_ERR_O(ferr),
    .EXIT_FS_O(xfs), .CLEAR_FAULTS_O(cflt), .CLEAR_POR_O(cpor), .ERR_O(err), .ERR_OE_O(err_oe),
    .CLEAR_REG_LOCKED_O(lk3), .CONFIG_LOCKED_O(lk2), .CURRENT_LOCKED_O(lk1),
    .DUTY_LOCKED_O(lk0), .STAY_EEPROM_O(stay), .EEPROM_OVERWRITE_O(eeov), .ADC_CH_O(ch),
    .ADC_START_O(adc_go), .IRQ_O(irq)
  );

  // A 25 ns clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Guards against a hang; the whole run needs about a hundred cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Returns 1 ns into the cycle after the given edge count, so outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write; returns inside the cycle where the write's pulses stand.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask

  task automatic t_reset_vals;
    chk("lock_out", 8'h0F, {4'h0, lks});
    chk("threshold", 8'hA7, th);
    rdc("lock_rd", ADDR_LOCK, 8'h0F);
    rdc("eeadc_rd", ADDR_EEADC, 8'h00);
    rdc("unmapped", 8'h70, 8'h00);
  endtask

  task automatic t_locked;
    wr(ADDR_CLEAR, 8'h3F);
    chk("locked_pulses", 8'h00, {2'b00, pulses});
    wr(ADDR_SHORT_TH, 8'h11);
    tick(1);
    chk("locked_th", 8'hA7, th);
    wr(ADDR_EEADC, 8'h83);
    chk("locked_adc", 8'h00, {7'h0, adc_go});
    rdc("locked_eeadc", ADDR_EEADC, 8'h00);
    rdc("refused_st", ADDR_IRQ_STATUS, 8'h01);
  endtask

  // Each lock bit alone, so a swapped or stuck bit shows.
  task automatic t_lock_bits;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LOCK, 8'hF0 | (8'h01 << i));
      chk("lock_out", 8'h01 << i, {4'h0, lks});
      rdc("lock_rd", ADDR_LOCK, 8'h01 << i);
    end
    wr(ADDR_LOCK, 8'h00);
  endtask

  task automatic t_commands;
    int bits[4] = '{0, 1, 2, 5};
    foreach (bits[k]) begin
      wr(ADDR_CLEAR, 8'h01 << bits[k]);
      chk("cmd_pulse", 8'h01 << bits[k], {2'b00, pulses});
      tick(1);
      chk("cmd_end", 8'h00, {2'b00, pulses});
    end
    rdc("clear_rd", ADDR_CLEAR, 8'h00);
    ce <= 1'b0;
    wr(ADDR_CLEAR, 8'h01);
    chk("ce_frozen", 8'h00, {2'b00, pulses});
    ce <= 1'b1;
  endtask

  task automatic t_error;
    wr(ADDR_CLEAR, 8'h08);
    chk("oe_early", 8'h00, {7'h0, err_oe});
    chk("ferr_pulse", 8'h08, {2'b00, pulses});
    tick(1);
    chk("oe_low", 8'h01, {6'h0, err, err_oe});
    wr(ADDR_CLEAR, 8'h02);
    tick(3);
    chk("oe_clr", 8'h00, {7'h0, err_oe});
    fault <= 1'b1;
    tick(2);
    chk("oe_fault", 8'h01, {7'h0, err_oe});
    fault <= 1'b0;
    tick(2);
  endtask

  task automatic t_eeadc;
    wr(ADDR_EEADC, 8'h85);
    chk("adc_go", 8'h01, {7'h0, adc_go});
    chk("adc_ch", 8'h05, {3'h0, ch});
    chk("stay", 8'h01, {7'h0, stay});
    rdc("eeadc_rd", ADDR_EEADC, 8'h85);
    stored <= 8'h3C;
    wr(ADDR_EEADC, 8'h5F);
    chk("overwrite", 8'h01, {7'h0, eeov});
    tick(2);
    chk("reload_th", 8'h3C, th);
    rdc("eeadc_rd2", ADDR_EEADC, 8'h1F);
    wr(ADDR_SHORT_TH, 8'h96);
    rdc("th_rd", ADDR_SHORT_TH, 8'h96);
  endtask

  // Status holds all four events by now; mask, raise and clear one of them.
  task automatic t_irq;
    wr(ADDR_IRQ_MASK, 8'h00);
    chk("irq_masked", 8'h00, {7'h0, irq});
    rdc("irq_st", ADDR_IRQ_STATUS, 8'h0F);
    wr(ADDR_IRQ_MASK, 8'h02);
    chk("irq_on", 8'h01, {7'h0, irq});
    wr(ADDR_IRQ_STATUS, 8'h02);
    tick(1);
    chk("irq_off", 8'h00, {7'h0, irq});
    rdc("irq_w1c", ADDR_IRQ_STATUS, 8'h0D);
  endtask

  task automatic t_restore;
    wr(ADDR_LOCK, 8'h00);
    wr(ADDR_EEADC, 8'h9F);
    stored <= 8'h5A;
    wr(ADDR_CLEAR, 8'h10);
    chk("restore_pulse", 8'h10, {2'b00, pulses});
    tick(2);
    chk("restore_lock", 8'h0F, {4'h0, lks});
    chk("restore_th", 8'h5A, th);
    rdc("restore_ee", ADDR_EEADC, 8'h00);
  endtask

  initial begin
    rst_b  = 1'b0;
    ce     = 1'b1;
    wr_s   = 1'b0;
    rd_s   = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
    stored = 8'hA7;
    fault  = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    t_reset_vals();
    t_locked();
    t_lock_bits();
    t_commands();
    t_error();
    t_eeadc();
    t_irq();
    t_restore();
    wrap_up();
  end
endmodule
`default_nettype wire
